// File: rtl/scrc_defines.svh
`ifndef SCRC_DEFINES_SVH
`define SCRC_DEFINES_SVH

// byte address of the channel receive configuration register
`define SCRC_CFG_OFFSET 8'h00
// value after reset: only the reserved bit 2 is set
`define SCRC_CFG_RESET 8'h04
// mask of the bits that hold state and read back
`define SCRC_CFG_RW_MASK 8'h1F
// recovered byte clock divider at full and half rate
`define SCRC_DIV_FULL_RATE 3'h4
`define SCRC_DIV_HALF_RATE 3'h2
// rate select value meaning ten times the reference clock
`define SCRC_RATE_X10 1'b1

`endif

// File: rtl/scrc_pkg.sv
package scrc_pkg;

    typedef struct packed {
        logic [2:0] rsvdHigh;
        logic fcLinkFsmEnable;
        logic rxDecoderEnable;
        logic rsvdOne;
        logic rxPowerDown;
        logic rxRateSelect;
    } scrc_cfg_t;

    typedef logic [9:0] scrc_sym_t;

endpackage

// File: rtl/scrc_ctl_if.sv
`timescale 1ns/100ps

interface scrc_ctl_if;
    logic powerDown;
    logic decoderEnable;

    modport ctrl (
        output powerDown,
        output decoderEnable
    );

    modport path (
        input powerDown,
        input decoderEnable
    );
endinterface

// File: rtl/scrc_rx_path.sv
`timescale 1ns/100ps

module scrc_rx_path (
    input wire logic ref_clk,
    input wire logic reset_n,
    scrc_ctl_if.path ctl,
    input wire scrc_pkg::scrc_sym_t rxRawSym,
    input wire logic [7:0] rxDecData,
    input wire logic rxDecCtrl,
    output scrc_pkg::scrc_sym_t rxData
);

    ////////////////////////////////////////////////////////////////////////
    // delivered data: held at zero while powered down
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rxData <= 10'h000;
        end else if (ctl.powerDown) begin
            rxData <= 10'h000;
        end else if (ctl.decoderEnable) begin
            rxData <= {1'b0, rxDecCtrl, rxDecData};
        end else begin
            rxData <= rxRawSym;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    chk_pd_output_zero: assert property (
        ctl.powerDown |=> rxData == 10'h000
    ) else $error("data moved while receiver powered down");

    chk_decoded_path: assert property (
        ctl.decoderEnable && !ctl.powerDown
            |=> rxData == {1'b0, $past(rxDecCtrl), $past(rxDecData)}
    ) else $error("decoded data not delivered");

    chk_raw_path: assert property (
        !ctl.decoderEnable && !ctl.powerDown |=> rxData == $past(rxRawSym)
    ) else $error("raw data not delivered");

endmodule

// File: rtl/scrc_rx_channel_config.sv
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`include "scrc_defines.svh"

// How it works
// - power-down bit one shuts receive sections down; it resets to zero.
// - reserved bit 2 takes the value one at every reset.
// - decoder enable one delivers data through the 8b/10b decoder.
// - decoder enable zero delivers raw data; the bit resets to zero.
// - link state machine enable at bit 4 runs the link state machine.
// - link state machine enable zero keeps it disabled; resets to zero.
// - ten-gigabit attachment mode forces the link enable bit to be ignored.
// - rate select bit 0 picks ten or twenty times, byte clock scaled.
module scrc_rx_channel_config #(
    parameter int ADDR_W = 8
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire logic tenGigAttachModeSel,
    input wire scrc_pkg::scrc_sym_t rxRawSym,
    input wire logic [7:0] rxDecData,
    input wire logic rxDecCtrl,
    output scrc_pkg::scrc_sym_t rxData,
    output logic rxPowerDown,
    output logic rxDecoderEnable,
    output logic fcLinkFsmEnable,
    output logic rxRateSelect,
    output logic [2:0] rxByteClkDiv
);

    ////////////////////////////////////////////////////////////////////////
    // address decode

    function automatic logic hitsCfg(input logic [ADDR_W-1:0] addr);
        hitsCfg = (addr == ADDR_W'(`SCRC_CFG_OFFSET));
    endfunction

    scrc_pkg::scrc_cfg_t cfgReg;
    scrc_pkg::scrc_cfg_t cfgNext;
    logic cfgWrite;

    assign cfgWrite = regWr && hitsCfg(regAddr);

    ////////////////////////////////////////////////////////////////////////
    // configuration register

    always_comb begin
        cfgNext = scrc_pkg::scrc_cfg_t'(regWrData & `SCRC_CFG_RW_MASK);
        // reserved high bits never hold state
        cfgNext.rsvdHigh = 3'h0;
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cfgReg <= scrc_pkg::scrc_cfg_t'(`SCRC_CFG_RESET);
        end else if (cfgWrite) begin
            cfgReg <= cfgNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port: data stand for exactly one cycle after the strobe

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            regRdData <= 8'h00;
        end else if (regRd && hitsCfg(regAddr)) begin
            regRdData <= 8'(cfgReg) & `SCRC_CFG_RW_MASK;
        end else begin
            regRdData <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control outputs

    scrc_ctl_if ctlBus ();

    assign ctlBus.powerDown = cfgReg.rxPowerDown;
    assign ctlBus.decoderEnable = cfgReg.rxDecoderEnable;
    assign rxPowerDown = cfgReg.rxPowerDown;
    assign rxDecoderEnable = cfgReg.rxDecoderEnable;

    // attachment mode overrides the link enable completely
    assign fcLinkFsmEnable = cfgReg.fcLinkFsmEnable && !tenGigAttachModeSel;

    assign rxRateSelect = cfgReg.rxRateSelect;
    assign rxByteClkDiv = (cfgReg.rxRateSelect == `SCRC_RATE_X10)
        ? `SCRC_DIV_FULL_RATE : `SCRC_DIV_HALF_RATE;

    ////////////////////////////////////////////////////////////////////////
    // receive datapath

    scrc_rx_path u_path (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .ctl(ctlBus.path),
        .rxRawSym(rxRawSym),
        .rxDecData(rxDecData),
        .rxDecCtrl(rxDecCtrl),
        .rxData(rxData)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    chk_pd_reset_zero: assert property (
        $rose(reset_n) |-> !rxPowerDown
    ) else $error("power down not zero after reset");

    chk_pd_write_takes: assert property (
        cfgWrite |=> rxPowerDown == $past(regWrData[1])
    ) else $error("power down bit not written");

    chk_rsvd_one_reset: assert property (
        $rose(reset_n) ##1 (regRd && hitsCfg(regAddr) && !$past(cfgWrite))
            |=> regRdData[2]
    ) else $error("reserved bit 2 not one after reset");

    chk_dec_reset_off: assert property (
        $rose(reset_n) |-> !rxDecoderEnable
    ) else $error("decoder enabled after reset");

    chk_dec_write_takes: assert property (
        cfgWrite |=> rxDecoderEnable == $past(regWrData[3])
    ) else $error("decoder enable not written");

    chk_fsm_write_on: assert property (
        cfgWrite && regWrData[4] ##1 !tenGigAttachModeSel |-> fcLinkFsmEnable
    ) else $error("link state machine not enabled");

    chk_fsm_reset_off: assert property (
        $rose(reset_n) |-> !fcLinkFsmEnable
    ) else $error("link state machine on after reset");

    chk_fsm_bit_off: assert property (
        cfgWrite && !regWrData[4] |=> !fcLinkFsmEnable [*2]
            or (cfgWrite || regWr) [*1]
    ) else $error("link state machine on while bit clear");

    chk_fsm_override: assert property (
        tenGigAttachModeSel |-> !fcLinkFsmEnable
    ) else $error("link enable honoured in attachment mode");

    chk_rsvd_high_zero: assert property (
        regRd |=> regRdData[7:5] == 3'h0
    ) else $error("reserved high bits read nonzero");

    chk_rate_divider: assert property (
        cfgWrite |=> rxByteClkDiv == ($past(regWrData[0])
            ? `SCRC_DIV_FULL_RATE : `SCRC_DIV_HALF_RATE)
    ) else $error("byte clock divider does not follow rate");

    chk_read_one_cycle: assert property (
        regRd ##1 !regRd |=> regRdData == 8'h00
    ) else $error("read data stood longer than one cycle");

    chk_read_value: assert property (
        regRd && hitsCfg(regAddr) && !$past(cfgWrite)
            |=> regRdData == (8'($past(cfgReg)) & `SCRC_CFG_RW_MASK)
    ) else $error("read data do not match register");

    chk_rate_write_takes: assert property (
        cfgWrite |=> rxRateSelect == $past(regWrData[0])
    ) else $error("rate select not written");

    chk_rate_reset_low: assert property (
        $rose(reset_n)
            |-> !rxRateSelect && rxByteClkDiv == `SCRC_DIV_HALF_RATE
    ) else $error("rate select not low after reset");

    chk_rsvd_one_write: assert property (
        cfgWrite |=> cfgReg.rsvdOne == $past(regWrData[2])
    ) else $error("reserved bit 2 not stored");

    chk_ctl_hold_idle: assert property (
        !cfgWrite |=> $stable(cfgReg)
    ) else $error("configuration changed without a write");

    chk_fsm_mode_release: assert property (
        $fell(tenGigAttachModeSel) && cfgReg.fcLinkFsmEnable
            |-> fcLinkFsmEnable
    ) else $error("link state machine not back after attachment mode");

    chk_read_idle_zero: assert property (
        !regRd |=> regRdData == 8'h00
    ) else $error("read data present without a read");

    chk_unmapped_read: assert property (
        regRd && !hitsCfg(regAddr) |=> regRdData == 8'h00
    ) else $error("unmapped read returned data");

    chk_read_after_write: assert property (
        cfgWrite ##1 (regRd && hitsCfg(regAddr))
            |=> regRdData == ($past(regWrData, 2) & `SCRC_CFG_RW_MASK)
    ) else $error("read after write missed the new value");

    cov_decoder_on: cover property (
        cfgWrite && regWrData[3] ##1 !rxPowerDown [*3]
    );

    cov_fsm_override: cover property (
        cfgReg.fcLinkFsmEnable && tenGigAttachModeSel
    );

    cov_power_down: cover property (
        cfgWrite && regWrData[1] ##2 rxData == 10'h000
    );

    cov_write_read: cover property (
        cfgWrite ##1 (regRd && hitsCfg(regAddr))
    );

    cov_read_after_reset: cover property (
        $rose(reset_n) ##1 regRd
    );

endmodule

// File: bench/tb.sv
`timescale 1ns/100ps
`include "scrc_defines.svh"

module tb;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic tenGigAttachModeSel = 1'b0;
    logic rxDecCtrl = 1'b0;
    logic [7:0] rxDecData = 8'h00;
    scrc_pkg::scrc_sym_t rxRawSym = 10'h000;
    scrc_pkg::scrc_sym_t rxData;
    logic [7:0] regRdData;
    logic rxPowerDown;
    logic rxDecoderEnable;
    logic fcLinkFsmEnable;
    logic rxRateSelect;
    logic [2:0] rxByteClkDiv;
    logic [7:0] rd;
    int fails = 0;
    int checkCount = 0;
    // row: write data, attach mode, then {powerDown, decoder, linkFsm, rate, div}
    logic [15:0] rows [8] = '{16'h050c, 16'h0642, 16'h0c22, 16'h1412,
                              16'h1482, 16'hffec, 16'hff7c, 16'h0002};

    always #5 ref_clk = ~ref_clk;

    scrc_rx_channel_config #(.ADDR_W(8)) dut (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .regAddr(regAddr),
        .regWrData(regWrData),
        .regWr(regWr),
        .regRd(regRd),
        .regRdData(regRdData),
        .tenGigAttachModeSel(tenGigAttachModeSel),
        .rxRawSym(rxRawSym),
        .rxDecData(rxDecData),
        .rxDecCtrl(rxDecCtrl),
        .rxData(rxData),
        .rxPowerDown(rxPowerDown),
        .rxDecoderEnable(rxDecoderEnable),
        .fcLinkFsmEnable(fcLinkFsmEnable),
        .rxRateSelect(rxRateSelect),
        .rxByteClkDiv(rxByteClkDiv)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        checkCount++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
        #1;
    endtask

    task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        d = regRdData;
    endtask

    task automatic checkOuts(input logic [6:0] e);
        check("powerDown", rxPowerDown, e[6]);
        check("decoderEnable", rxDecoderEnable, e[5]);
        check("linkFsmEnable", fcLinkFsmEnable, e[4]);
        check("rateSelect", rxRateSelect, e[3]);
        check("byteClkDiv", rxByteClkDiv, e[2:0]);
    endtask

    task automatic doReset();
        @(posedge ref_clk);
        reset_n <= 1'b0;
        @(posedge ref_clk);
        reset_n <= 1'b1;
        #1;
        checkOuts(7'h02);
        check("rxData", rxData, 10'h000);
        rdReg(8'h00, rd);
        check("resetValue", rd, 8'h04);
        $display("reset test done");
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #20000;
        fails++;
        summarize();
    end

    initial begin
        doReset();
        foreach (rows[i]) begin
            @(posedge ref_clk);
            tenGigAttachModeSel <= rows[i][7];
            wrReg(8'h00, rows[i][15:8]);
            checkOuts(rows[i][6:0]);
            rdReg(8'h00, rd);
            check("readback", rd, rows[i][15:8] & `SCRC_CFG_RW_MASK);
        end
        $display("table test done");
        // attach mode overrides link enable without any register write
        wrReg(8'h00, 8'h14);
        @(posedge ref_clk);
        tenGigAttachModeSel <= 1'b1;
        #1;
        check("linkFsmOverride", fcLinkFsmEnable, 1'b0);
        @(posedge ref_clk);
        tenGigAttachModeSel <= 1'b0;
        #1;
        check("linkFsmRestore", fcLinkFsmEnable, 1'b1);
        // datapath selection
        @(posedge ref_clk);
        rxRawSym <= 10'h2a5;
        rxDecData <= 8'h3c;
        rxDecCtrl <= 1'b1;
        wrReg(8'h00, 8'h04);
        @(posedge ref_clk);
        #1;
        check("rawPath", rxData, 10'h2a5);
        wrReg(8'h00, 8'h0c);
        @(posedge ref_clk);
        #1;
        check("decodedPath", rxData, 10'h13c);
        wrReg(8'h00, 8'h0e);
        @(posedge ref_clk);
        #1;
        check("poweredDown", rxData, 10'h000);
        $display("datapath test done");
        // write then read with no gap, data stands one cycle
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= 8'h00;
        regWrData <= 8'h0d;
        @(posedge ref_clk);
        regWr <= 1'b0;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        check("backToBack", regRdData, 8'h0d);
        @(posedge ref_clk);
        #1;
        check("readDataDrop", regRdData, 8'h00);
        // unmapped address
        wrReg(8'h01, 8'h1b);
        rdReg(8'h00, rd);
        check("unmappedWrite", rd, 8'h0d);
        rdReg(8'h01, rd);
        check("unmappedRead", rd, 8'h00);
        $display("bus test done");
        wrReg(8'h00, 8'hff);
        doReset();
        summarize();
    end
endmodule
